//--- src/bbp_bank.sv
// Bank buffered transfer: byte packing, unpacking and pattern match.
// Assumes handshake and data inputs synchronous to i_sys_clk; one strobe per sample.
//
// How it works
// - Width change marks bank traces invalid
// - Byte mode outputs one byte per handshake
// - Word mode outputs two bytes per handshake
// - Quad mode outputs four bytes per handshake
// - Word output: first byte on bits 15:8
// - Quad output: first byte on bits 31:24
// - One global byte swap for all transfers
// - Byte mode stores one byte per handshake
// - Word mode stores two bytes per handshake
// - Quad mode stores four bytes per handshake
// - Word input: bits 15:8 to first byte
// - Quad input: bits 31:24 to first byte
// - Compare only on input banks
// - Compare works with or without handshake
// - Match drives interrupt and/or alarm
// - Match can start or stop capture
// - Compare from bit zero over width
// - Poll data; interrupt while pattern equal
// - Compare enable arms the alarm
// - Match-started capture stops after count
// - Interrupt drops when condition is gone
// - Zero count captures endlessly, wrapping
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module bbp_bank
	import bbp_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [31:0] i_data,
	input wire logic i_strobe,
	output logic [31:0] o_data,
	output logic o_data_oe,
	output logic o_strobe,
	output logic o_bank_interrupt_line,
	output logic o_bank_interrupt_line_oe,
	output logic o_alarm
);
	bbp_mem_if mif ();
	bbp_mem u_mem (
		.i_sys_clk(i_sys_clk),
		.mem(mif.slave)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [10:0] ctrl_r;
	logic [31:0] pattern_r;
	logic [CNT_W-1:0] count_r;
	logic [ADDR_W-1:0] host_addr_r;
	logic valid_r;
	wire [1:0] width_sel = ctrl_r[CTRL_WIDTH_LSB +: 2];
	wire dir_in = ctrl_r[CTRL_DIR_IN];
	wire swap = ctrl_r[CTRL_SWAP];
	wire cmp_en = ctrl_r[CTRL_CMP_EN];
	wire irq_en = ctrl_r[CTRL_IRQ_EN];
	wire [1:0] irq_mode = ctrl_r[CTRL_IRQ_MODE_LSB +: 2];
	wire [1:0] act = ctrl_r[CTRL_ACT_LSB +: 2];
	wire hs_en = ctrl_r[CTRL_HS_EN];
	wire wr_ctrl = i_wr && i_addr == REG_CTRL;
	wire wr_cmd = i_wr && i_addr == REG_CMD;
	wire wr_mem = i_wr && i_addr == REG_MEM_DATA;
	wire width_change = wr_ctrl && i_wdata[CTRL_WIDTH_LSB +: 2] != width_sel;
	wire cmd_start = wr_cmd && i_wdata[CMD_START];
	wire cmd_stop = wr_cmd && i_wdata[CMD_STOP];
	wire cmd_clear = wr_cmd && i_wdata[CMD_CLEAR];

	////////////////////////////////////////////////////////////////////////////////
	// Sample geometry
	wire [2:0] nbytes = width_sel == WIDTH_QUAD ? 3'h4 : width_sel == WIDTH_WORD ? 3'h2 : 3'h1;
	wire [ADDR_W-1:0] step = width_sel == WIDTH_QUAD ? STEP_QUAD :
		width_sel == WIDTH_WORD ? STEP_WORD : STEP_BYTE;
	wire [31:0] width_mask = width_sel == WIDTH_QUAD ? 32'hffffffff :
		width_sel == WIDTH_WORD ? 32'h0000ffff : 32'h000000ff;
	wire [ADDR_W-1:0] mem_limit = ADDR_ZERO - step;

	////////////////////////////////////////////////////////////////////////////////
	// Pattern compare
	logic match_r;
	wire cmp_hit = cmp_en && dir_in &&
		((i_data & width_mask) == (pattern_r & width_mask));
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			match_r <= 1'b0;
		end else begin
			match_r <= cmp_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer engine: one sample is a burst of byte cycles
	bbp_state_type state_r, state_nxt;
	logic [ADDR_W-1:0] base_r;
	logic [ADDR_W-1:0] wr_ptr_r;
	logic [CNT_W-1:0] done_r;
	logic [2:0] bcnt_r;
	logic busy_r;
	logic [31:0] samp_r;
	logic full_r;
	logic [31:0] out_r;
	logic pend_r;
	logic pend_last_r;
	logic [4:0] pend_shift_r;

	wire run = state_r == ST_RUN;
	wire strobe_ok = hs_en ? i_strobe : 1'b1;
	wire start_ev = cmd_start || (match_r && act == ACT_START);
	wire stop_ev = cmd_stop || (match_r && act == ACT_STOP);
	wire take = run && !busy_r && strobe_ok && !wr_mem;
	wire last_byte = bcnt_r == nbytes - 3'h1;
	wire sample_end = busy_r && last_byte;
	wire count_hit = count_r != COUNT_ENDLESS && done_r + COUNT_ONE == count_r;

	// Byte lane k of a sample; lane 0 is most significant, at the lowest address unless swap is set
	wire [2:0] lane = swap ? nbytes - 3'h1 - bcnt_r : bcnt_r;
	wire [2:0] lane_pos = nbytes - 3'h1 - lane;
	wire [4:0] shift = {lane_pos[1:0], 3'h0};
	wire [7:0] in_byte = 8'(samp_r >> shift);
	wire [31:0] rd_lane = {24'h0, mif.rdata} << pend_shift_r;
	wire [31:0] packed_word = out_r | rd_lane;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_ev && valid_r) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (stop_ev || (sample_end && count_hit)) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				if (start_ev && valid_r) begin
					state_nxt = ST_RUN;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	wire [ADDR_W-1:0] eng_addr = base_r + ADDR_W'(bcnt_r);
	assign mif.we = wr_mem || (busy_r && dir_in);
	assign mif.addr = wr_mem ? host_addr_r : busy_r ? eng_addr : host_addr_r;
	assign mif.wdata = wr_mem ? i_wdata[7:0] : in_byte;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || cmd_clear || (start_ev && state_r != ST_RUN)) begin
			base_r <= ADDR_ZERO;
			done_r <= COUNT_ENDLESS;
			bcnt_r <= 3'h0;
			busy_r <= 1'b0;
			full_r <= 1'b0;
			samp_r <= 32'h0;
		end else if (take) begin
			busy_r <= 1'b1;
			bcnt_r <= 3'h0;
			samp_r <= i_data;
		end else if (busy_r) begin
			bcnt_r <= bcnt_r + 3'h1;
			if (last_byte) begin
				busy_r <= 1'b0;
				bcnt_r <= 3'h0;
				done_r <= done_r + COUNT_ONE;
				base_r <= base_r == mem_limit ? ADDR_ZERO : base_r + step;
				if (base_r == mem_limit) begin
					full_r <= 1'b1;
				end
			end
		end
	end

	// A lane's memory byte arrives one cycle after its address; the packed
	// sample is launched together with its strobe so the far side logs it there
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pend_r <= 1'b0;
			pend_last_r <= 1'b0;
			pend_shift_r <= 5'h0;
			out_r <= 32'h0;
			o_data <= 32'h0;
			o_strobe <= 1'b0;
			o_data_oe <= 1'b0;
		end else begin
			o_data_oe <= !dir_in && run;
			o_strobe <= 1'b0;
			pend_r <= busy_r && !dir_in;
			pend_last_r <= busy_r && !dir_in && last_byte;
			pend_shift_r <= shift;
			if (pend_r) begin
				out_r <= pend_last_r ? 32'h0 : packed_word;
				if (pend_last_r) begin
					o_data <= packed_word;
					o_strobe <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host side registers
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ctrl_r <= 11'h0;
			pattern_r <= 32'h0;
			count_r <= COUNT_ENDLESS;
			host_addr_r <= ADDR_ZERO;
			valid_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= i_wdata[10:0];
			end
			if (i_wr && i_addr == REG_PATTERN) begin
				pattern_r <= i_wdata;
			end
			if (i_wr && i_addr == REG_COUNT) begin
				count_r <= i_wdata[CNT_W-1:0];
			end
			if (i_wr && i_addr == REG_MEM_ADDR) begin
				host_addr_r <= i_wdata[ADDR_W-1:0];
			end else if (wr_mem) begin
				host_addr_r <= host_addr_r + STEP_BYTE;
			end
			if (width_change || (wr_ctrl && i_wdata[CTRL_DIR_IN] != dir_in) || cmd_clear) begin
				valid_r <= 1'b0;
			end else if (wr_mem || (dir_in && wr_cmd)) begin
				valid_r <= 1'b1;
			end
		end
	end

	wire [31:0] status_word = {8'h0, done_r, 4'h0, match_r, full_r, run, valid_r};
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h0;
		end else begin
			if (i_rd) begin
				case (i_addr)
					REG_CTRL: o_rdata <= {21'h0, ctrl_r};
					REG_PATTERN: o_rdata <= pattern_r;
					REG_COUNT: o_rdata <= {16'h0, count_r};
					REG_STATUS: o_rdata <= status_word;
					REG_MEM_ADDR: o_rdata <= {15'h0, host_addr_r};
					default: o_rdata <= 32'h0;
				endcase
			end else begin
				o_rdata <= 32'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt and alarm
	wire irq_cond = irq_mode == IRQ_MODE_MATCH ? match_r : full_r;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_bank_interrupt_line <= 1'b0;
			o_bank_interrupt_line_oe <= 1'b0;
			o_alarm <= 1'b0;
		end else begin
			o_bank_interrupt_line <= irq_en && dir_in && irq_cond;
			o_bank_interrupt_line_oe <= dir_in;
			o_alarm <= cmp_en && match_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence seq_match_start;
		state_r != ST_RUN && valid_r && match_r && act == ACT_START;
	endsequence

	sequence seq_match_stop;
		run && match_r && act == ACT_STOP;
	endsequence

	sequence seq_match_irq;
		cmp_hit ##1 (match_r && irq_en && dir_in && irq_mode == IRQ_MODE_MATCH);
	endsequence

	chk_alarm_follows_match: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		match_r && cmp_en |=> o_alarm) else $error("alarm missed match");
	chk_no_out_match: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!dir_in |=> !match_r) else $error("match on output bank");
	chk_irq_drops: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!irq_cond |=> !o_bank_interrupt_line) else $error("interrupt stuck");
	chk_invalid_width: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		width_change |=> !valid_r) else $error("trace kept valid");
	chk_match_reg: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		cmp_hit |=> match_r) else $error("match not registered");
	chk_step_size: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		sample_end && base_r != mem_limit && !cmd_clear && !start_ev |=>
		base_r == $past(base_r) + $past(step)) else $error("bad advance");
	chk_count_stop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		run && sample_end && count_hit |=> state_r == ST_DONE) else $error("count overrun");
	chk_start_on_match: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		seq_match_start |=> run) else $error("match start missed");
	chk_stop_on_match: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		seq_match_stop |=> state_r == ST_DONE) else $error("match stop missed");
	chk_irq_on_match: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		seq_match_irq |=> o_bank_interrupt_line) else $error("interrupt missed match");
	chk_strobe_single: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_strobe |=> !o_strobe) else $error("strobe too long");
	chk_endless_count: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		count_r == COUNT_ENDLESS |-> !count_hit) else $error("endless capture ended");
	chk_first_lane: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		busy_r && dir_in && !wr_mem && !swap && bcnt_r == 3'h0 |-> mif.wdata ==
		(width_sel == WIDTH_QUAD ? samp_r[31:24] : width_sel == WIDTH_WORD ? samp_r[15:8] :
		samp_r[7:0])) else $error("first byte lane wrong");
	chk_alarm_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!cmp_en |=> !o_alarm) else $error("alarm without compare");
	chk_valid_start: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		state_r != ST_RUN && !valid_r |=> !run) else $error("invalid trace started");
	chk_bank_interrupt_line_input: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!dir_in |=> !o_bank_interrupt_line) else $error("interrupt on output bank");
	chk_oe_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!run |=> !o_data_oe) else $error("data driven while idle");
	chk_oe_output: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		run && !dir_in |=> o_data_oe) else $error("data not driven");
	chk_busy_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		busy_r && !last_byte && !cmd_clear && !(start_ev && state_r != ST_RUN) |=> busy_r)
		else $error("sample cut short");
endmodule

//--- inc/bbp_pkg.sv
// Constants, modes and types for the bank buffer packing and pattern match block.
// Assumes one system clock; all consumers import the whole package.
package bbp_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 17;
	localparam int CNT_W = 16;
	localparam int MEM_DEPTH = 131072;
	localparam logic [1:0] WIDTH_BYTE = 2'h0;
	localparam logic [1:0] WIDTH_WORD = 2'h1;
	localparam logic [1:0] WIDTH_QUAD = 2'h2;
	localparam logic [ADDR_W-1:0] STEP_BYTE = 17'h00001;
	localparam logic [ADDR_W-1:0] STEP_WORD = 17'h00002;
	localparam logic [ADDR_W-1:0] STEP_QUAD = 17'h00004;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h00000;
	localparam logic [CNT_W-1:0] COUNT_ENDLESS = 16'h0000;
	localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
	localparam logic [1:0] IRQ_MODE_FULL = 2'h0;
	localparam logic [1:0] IRQ_MODE_MATCH = 2'h1;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_START = 2'h1;
	localparam logic [1:0] ACT_STOP = 2'h2;
	// Register indices on the plain register port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_PATTERN = 4'h1;
	localparam logic [3:0] REG_COUNT = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_MEM_ADDR = 4'h4;
	localparam logic [3:0] REG_MEM_DATA = 4'h5;
	localparam logic [3:0] REG_CMD = 4'h6;
	// Control register fields
	localparam int CTRL_WIDTH_LSB = 0;
	localparam int CTRL_DIR_IN = 2;
	localparam int CTRL_SWAP = 3;
	localparam int CTRL_CMP_EN = 4;
	localparam int CTRL_IRQ_EN = 5;
	localparam int CTRL_IRQ_MODE_LSB = 6;
	localparam int CTRL_ACT_LSB = 8;
	localparam int CTRL_HS_EN = 10;
	// Command register bits
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_CLEAR = 2;
	// Status register fields
	localparam int STAT_VALID = 0;
	localparam int STAT_RUN = 1;
	localparam int STAT_FULL = 2;
	localparam int STAT_MATCH = 3;
	localparam int STAT_POINTS_LSB = 8;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_DONE = 3'b100
	} bbp_state_type;
endpackage

//--- inc/bbp_mem_if.sv
// Byte port between the transfer engine and the bank memory.
// Assumes a single clock; read data arrive one cycle after the request.
`timescale 1ns/100ps
interface bbp_mem_if;
	logic we;
	logic [16:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport master (output we, output addr, output wdata, input rdata);
	modport slave (input we, input addr, input wdata, output rdata);
endinterface

//--- src/bbp_mem.sv
// Bank byte memory with registered read data.
// Assumes synchronous single-port use by the transfer engine.
`timescale 1ns/100ps
module bbp_mem
	import bbp_pkg::*;
(
	input wire logic i_sys_clk,
	bbp_mem_if.slave mem
);
	logic [7:0] store [MEM_DEPTH];
	always_ff @(posedge i_sys_clk) begin
		if (mem.we) begin
			store[mem.addr] <= mem.wdata;
		end
		mem.rdata <= store[mem.addr];
	end
endmodule

//--- bench/bbp_far.sv
// Far-side digital system: drives bank data and handshake, logs samples it receives.
// Assumes the bank clock; lines change only just after rising edges.
`timescale 1ns/100ps
module bbp_far_model (
	input wire logic i_sys_clk,
	input wire logic [31:0] i_data,
	input wire logic i_strobe,
	output logic [31:0] o_data,
	output logic o_strobe
);
	logic [31:0] rx_q[$];
	initial begin
		o_data = 32'h0;
		o_strobe = 1'b0;
	end
	// Log each output sample on its one-cycle strobe
	always @(posedge i_sys_clk) begin
		if (i_strobe === 1'b1) begin
			rx_q.push_back(i_data);
		end
	end
	task automatic hold(input logic [31:0] v);
		@(posedge i_sys_clk);
		o_data <= v;
	endtask
	// After the strobe the sample is no longer guaranteed, so show its inverse
	task automatic send(input logic [31:0] v);
		@(posedge i_sys_clk);
		o_data <= v;
		o_strobe <= 1'b1;
		@(posedge i_sys_clk);
		o_strobe <= 1'b0;
		o_data <= ~v;
	endtask
endmodule

//--- bench/tb_top.sv
// Bench for the bank transfer block: register access, playback, match and capture.
// Assumes the far-side model and the package register map.
`timescale 1ns/100ps
module tb_top
	import bbp_pkg::*;
;
	logic i_sys_clk, i_rst, i_wr, i_rd, i_strobe;
	logic [3:0] i_addr;
	logic [31:0] i_wdata, i_data, o_rdata, o_data;
	logic o_data_oe, o_strobe, o_bank_interrupt_line, o_bank_interrupt_line_oe, o_alarm;
	int n_fail = 0;
	int cmp_count = 0;
	bbp_bank uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_data(i_data), .i_strobe(i_strobe),
		.o_data(o_data), .o_data_oe(o_data_oe), .o_strobe(o_strobe), .o_bank_interrupt_line(o_bank_interrupt_line),
		.o_bank_interrupt_line_oe(o_bank_interrupt_line_oe), .o_alarm(o_alarm));
	bbp_far_model far (.i_sys_clk(i_sys_clk), .i_data(o_data), .i_strobe(o_strobe),
		.o_data(i_data), .o_strobe(i_strobe));
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [31:0] v;
		rd(REG_STATUS, v);
		chk("status after reset", 32'h0, v);
		rd(4'hf, v);
		chk("unmapped read", 32'h0, v);
		rd(REG_MEM_DATA, v);
		chk("mem data read", 32'h0, v);
		chk("bank_interrupt_line after reset", 32'h0, {31'h0, o_bank_interrupt_line});
		$display("t_reset done");
	endtask
	task automatic t_out_nomatch;
		wr(REG_PATTERN, 32'h8c);
		wr(REG_CTRL, 32'h70);
		far.hold(32'h8c);
		cyc(4);
		chk("bank_interrupt_line on output bank", 32'h0, {31'h0, o_bank_interrupt_line});
		chk("alarm on output bank", 32'h0, {31'h0, o_alarm});
		chk("bank_interrupt_line oe on output bank", 32'h0, {31'h0, o_bank_interrupt_line_oe});
		$display("t_out_nomatch done");
	endtask
	task automatic t_match;
		far.hold(32'hffffff8c);
		wr(REG_CTRL, 32'h74);
		cyc(3);
		chk("bank_interrupt_line on match", 32'h1, {31'h0, o_bank_interrupt_line});
		chk("alarm on match", 32'h1, {31'h0, o_alarm});
		chk("bank_interrupt_line oe on input bank", 32'h1, {31'h0, o_bank_interrupt_line_oe});
		far.hold(32'hffffff8d);
		cyc(3);
		chk("bank_interrupt_line after mismatch", 32'h0, {31'h0, o_bank_interrupt_line});
		$display("t_match done");
	endtask
	task automatic t_play(input logic [31:0] ctrl, input int cnt, input logic [31:0] e0,
		input logic [31:0] e1);
		far.rx_q.delete();
		wr(REG_CTRL, ctrl);
		wr(REG_MEM_ADDR, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(REG_MEM_DATA, {24'h0, 8'h12 + 8'h22 * i[7:0]});
		end
		wr(REG_COUNT, cnt);
		wr(REG_CMD, 32'h1);
		cyc(1);
		chk("data oe while playing", 32'h1, {31'h0, o_data_oe});
		for (int k = 0; k < 300 && far.rx_q.size() < cnt; k++) begin
			@(posedge i_sys_clk);
		end
		#1;
		chk("sample count", cnt, far.rx_q.size());
		chk("data oe after playback", 32'h0, {31'h0, o_data_oe});
		if (far.rx_q.size() > 0) begin
			chk("first sample", e0, far.rx_q[0]);
		end
		if (cnt > 1 && far.rx_q.size() > 1) begin
			chk("second sample", e1, far.rx_q[1]);
		end
		wr(REG_CMD, 32'h2);
		$display("t_play ctrl %h done", ctrl);
	endtask
	task automatic t_inval;
		logic [31:0] v;
		rd(REG_STATUS, v);
		chk("valid before width change", 32'h1, {31'h0, v[STAT_VALID]});
		wr(REG_CTRL, 32'h8);
		rd(REG_STATUS, v);
		chk("valid after width change", 32'h0, {31'h0, v[STAT_VALID]});
		$display("t_inval done");
	endtask
	task automatic t_trig;
		logic [31:0] v;
		wr(REG_CTRL, 32'h514);
		wr(REG_COUNT, 32'h3);
		wr(REG_CMD, 32'h4);
		wr(REG_CMD, 32'h0);
		far.send(32'h01);
		rd(REG_STATUS, v);
		chk("points before match", 32'h0, {16'h0, v[23:8]});
		far.hold(32'h8c);
		cyc(3);
		for (int i = 1; i <= 5; i++) begin
			far.send(i);
		end
		cyc(6);
		rd(REG_STATUS, v);
		chk("points after match start", 32'h3, {16'h0, v[23:8]});
		chk("run after count", 32'h0, {31'h0, v[STAT_RUN]});
		$display("t_trig done");
	endtask
	task automatic t_cap;
		far.rx_q.delete();
		wr(REG_CTRL, 32'h406);
		wr(REG_COUNT, 32'h1);
		wr(REG_CMD, 32'h0);
		wr(REG_CMD, 32'h1);
		far.send(32'h12345678);
		cyc(6);
		wr(REG_CTRL, 32'h1);
		wr(REG_MEM_ADDR, 32'h100);
		wr(REG_MEM_DATA, 32'h0);
		wr(REG_COUNT, 32'h2);
		wr(REG_CMD, 32'h1);
		for (int k = 0; k < 300 && far.rx_q.size() < 2; k++) begin
			@(posedge i_sys_clk);
		end
		#1;
		chk("captured word count", 32'h2, far.rx_q.size());
		chk("captured high half", 32'h1234, far.rx_q[0]);
		chk("captured low half", 32'h5678, far.rx_q[1]);
		$display("t_cap done");
	endtask
	task automatic t_stop;
		logic [31:0] v;
		far.hold(32'h01);
		wr(REG_CTRL, 32'h214);
		wr(REG_COUNT, 32'h0);
		wr(REG_CMD, 32'h0);
		wr(REG_CMD, 32'h1);
		cyc(4);
		rd(REG_STATUS, v);
		chk("run before stop match", 32'h1, {31'h0, v[STAT_RUN]});
		far.hold(32'h8c);
		cyc(4);
		rd(REG_STATUS, v);
		chk("run after stop match", 32'h0, {31'h0, v[STAT_RUN]});
		$display("t_stop done");
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		n_fail++;
		$display("Watchdog expired");
		final_report();
	end
	initial begin
		i_rst = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 4'h0;
		i_wdata = 32'h0;
		repeat (3) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		t_reset();
		t_out_nomatch();
		t_match();
		t_play(32'h0, 2, 32'h12, 32'h34);
		t_play(32'h1, 2, 32'h1234, 32'h5678);
		t_play(32'h2, 1, 32'h12345678, 32'h0);
		t_play(32'h9, 2, 32'h3412, 32'h7856);
		t_inval();
		t_trig();
		t_cap();
		t_stop();
		final_report();
	end
endmodule
